// >>> include/pse_front_pkg.sv
package pse_front_pkg;
    // Fixed upper part of the seven-bit slave address
    localparam logic [2:0] ADDR_FIXED = 3'h2;
    // Number of power outputs
    localparam int NUM_PORTS = 4;
    // Reset values of held state
    localparam logic [7:0] SHIFT_RESET = 8'h00;
    localparam logic [3:0] EVENT_RESET = 4'h0;
    localparam logic [3:0] STRAP_RESET = 4'h0;
    localparam logic [2:0] BITCNT_RESET = 3'h0;
    // Synchroniser reset: clock and data idle high, selects and straps low
    localparam logic [7:0] PIN_SYNC_RESET = 8'hC0;
    // Address bit of the read/write flag
    localparam int RW_BIT = 0;
    // Cycles after reset release before straps are captured
    localparam logic [1:0] STRAP_SETTLE = 2'h3;
    // Slave protocol states
    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_DATA, ST_DATA_ACK, ST_READ, ST_READ_ACK
    } slave_state_t;
endpackage

// >>> core/poe_pse_pin_host_front_end.sv
// Operation
// RULE1: Mode input high selects hardware operation.
// RULE2: Undriven mode inputs default to low.
// RULE3: Midspan input high selects midspan behaviour.
// RULE4: Alert low while any enabled event pends.
// RULE5: Data sent on output, received on input.
// RULE6: Serial clock is input only.
// RULE7: Four straps form variable address part.
// RULE8: Ports powered only for valid devices.
// RULE9: Address is 010, straps 3..0, then R/W.
// RULE10: Alert changes only between transactions.
// RULE11: Host ties data lines, idles high.
// RULE12: Mode and midspan sampled at power-up.
// RULE13: Acknowledge only frames matching strapped address.
`timescale 1ns/1ps
`default_nettype none
module poe_pse_pin_host_front_end
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic mode_sel,
    input wire logic mid_sel,
    input wire logic addr_strap_0,
    input wire logic addr_strap_1,
    input wire logic addr_strap_2,
    input wire logic addr_strap_3,
    input wire logic scl,
    input wire logic serial_data_in,
    output logic serial_data_out_oe,
    output logic serial_data_out,
    output logic alert_n_oe,
    output logic alert_n,
    input wire logic [pse_front_pkg::NUM_PORTS-1:0] pd_valid,
    input wire logic [pse_front_pkg::NUM_PORTS-1:0] port_event,
    input wire logic [pse_front_pkg::NUM_PORTS-1:0] port_power_req,
    output logic [pse_front_pkg::NUM_PORTS-1:0] port_power_en,
    output logic hw_mode,
    output logic midspan_mode
);
    import pse_front_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers
    ////////////////////////////////////////////////////////////////////////
    // Pin bundle: scl, sda, mode, mid, straps 3..0
    wire logic [7:0] pin_raw;
    logic [7:0] pin_s1_r;
    logic [7:0] pin_s2_r;
    assign pin_raw = {scl, serial_data_in, mode_sel, mid_sel,
                      addr_strap_3, addr_strap_2, addr_strap_1, addr_strap_0};

    // Two stages; only the second stage is read by logic
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_r <= PIN_SYNC_RESET;
            pin_s2_r <= PIN_SYNC_RESET;
        end else begin
            pin_s1_r <= pin_raw;
            pin_s2_r <= pin_s1_r;
        end
    end

    wire logic scl_s;
    wire logic sda_s;
    assign scl_s = pin_s2_r[7];
    assign sda_s = pin_s2_r[6];

    ////////////////////////////////////////////////////////////////////////
    // Power-up strap capture
    ////////////////////////////////////////////////////////////////////////
    // Settle counter lets the synchronisers fill before capture
    logic [1:0] settle_r;
    logic captured_r;
    logic [3:0] strap_r;
    wire logic capture_now;
    assign capture_now = !captured_r && (settle_r == STRAP_SETTLE);

    // RULE12: sample once after reset
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            settle_r <= 2'h0;
            captured_r <= 1'b0;
            strap_r <= STRAP_RESET;
            hw_mode <= 1'b0;
            midspan_mode <= 1'b0;
        end else begin
            if (!captured_r && settle_r != STRAP_SETTLE) begin
                settle_r <= settle_r + 2'h1;
            end
            if (capture_now) begin
                captured_r <= 1'b1;
                // RULE7: four straps latched
                strap_r <= pin_s2_r[3:0];
                // RULE1: high means hardware mode
                // RULE2: low reset value matches pull-down default
                hw_mode <= pin_s2_r[5];
                // RULE3: high means midspan
                midspan_mode <= pin_s2_r[4];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus condition detection
    ////////////////////////////////////////////////////////////////////////
    logic scl_d_r;
    logic sda_d_r;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_d_r <= scl_s;
            sda_d_r <= sda_s;
        end
    end

    // RULE6: clock is observed, never driven
    wire logic scl_rise;
    wire logic scl_fall;
    wire logic start_cond;
    wire logic stop_cond;
    assign scl_rise = scl_s && !scl_d_r;
    assign scl_fall = !scl_s && scl_d_r;
    assign start_cond = scl_s && scl_d_r && sda_d_r && !sda_s;
    assign stop_cond = scl_s && scl_d_r && !sda_d_r && sda_s;

    ////////////////////////////////////////////////////////////////////////
    // Slave protocol engine
    ////////////////////////////////////////////////////////////////////////
    slave_state_t state_r;
    slave_state_t state_nxt;
    logic [7:0] shift_r;
    logic [2:0] bitcnt_r;
    logic busy_r;
    logic [7:0] rdata_r;
    // Second half of an acknowledge, or last read bit on the line; restarts on every state change
    logic phase_r;
    wire logic phase_set;
    wire logic phase_nxt;
    assign phase_set = (scl_fall && (state_r == ST_ADDR_ACK || state_r == ST_DATA_ACK))
                       || (scl_rise && state_r == ST_READ && bitcnt_r == 3'h7)
                       || (scl_rise && state_r == ST_READ_ACK && !sda_s);
    assign phase_nxt = (state_nxt == state_r) && (phase_r || phase_set);

    // RULE9: own address is 010 then straps
    wire logic [6:0] own_addr;
    wire logic addr_hit;
    wire logic [7:0] shift_in;
    assign own_addr = {ADDR_FIXED, strap_r};
    assign shift_in = {shift_r[6:0], sda_s};
    // RULE13: match on the full seven bits
    assign addr_hit = (shift_in[7:1] == own_addr);

    // Next state on clock edges
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: state_nxt = ST_IDLE;
            ST_ADDR: begin
                if (scl_rise && bitcnt_r == 3'h7) begin
                    state_nxt = addr_hit ? ST_ADDR_ACK : ST_IDLE;
                end
            end
            ST_ADDR_ACK: begin
                if (scl_fall && phase_r) begin
                    state_nxt = shift_r[RW_BIT] ? ST_READ : ST_DATA;
                end
            end
            ST_DATA: begin
                if (scl_rise && bitcnt_r == 3'h7) begin
                    state_nxt = ST_DATA_ACK;
                end
            end
            ST_DATA_ACK: begin
                if (scl_fall && phase_r) begin
                    state_nxt = ST_DATA;
                end
            end
            ST_READ: begin
                if (scl_fall && phase_r) begin
                    state_nxt = ST_READ_ACK;
                end
            end
            ST_READ_ACK: begin
                // Master NACK ends the read; an ACK resumes only after the clock falls
                if (scl_rise && sda_s) begin
                    state_nxt = ST_IDLE;
                end else if (scl_fall && phase_r) begin
                    state_nxt = ST_READ;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
        if (start_cond) begin
            state_nxt = ST_ADDR;
        end else if (stop_cond) begin
            state_nxt = ST_IDLE;
        end
    end

    // Data and bit counting; read data returns port power status
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            shift_r <= SHIFT_RESET;
            bitcnt_r <= BITCNT_RESET;
            busy_r <= 1'b0;
            rdata_r <= SHIFT_RESET;
            phase_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            phase_r <= phase_nxt;
            if (start_cond) begin
                busy_r <= 1'b1;
                bitcnt_r <= BITCNT_RESET;
            end else if (stop_cond) begin
                busy_r <= 1'b0;
            end else if (scl_rise && (state_r == ST_ADDR || state_r == ST_DATA || state_r == ST_READ)) begin
                shift_r <= shift_in;
                bitcnt_r <= bitcnt_r + 3'h1;
            end
            // Load read byte when entering a read byte
            if (state_nxt == ST_READ && state_r != ST_READ) begin
                rdata_r <= {4'h0, port_power_en};
                bitcnt_r <= BITCNT_RESET;
            end else if (scl_fall && state_r == ST_READ && bitcnt_r != 3'h0) begin
                rdata_r <= {rdata_r[6:0], 1'b0};
            end
        end
    end

    // RULE5: drive low only through the data output
    wire logic sda_low_nxt;
    // Pull waits for the clock fall: moving data with the clock high would fake a start or stop
    assign sda_low_nxt = ((state_r == ST_ADDR_ACK || state_r == ST_DATA_ACK) && phase_r)
                         || (state_r == ST_READ && !rdata_r[7]);
    // Open-drain: output held low, enable asserts the pull
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            serial_data_out_oe <= 1'b0;
            serial_data_out <= 1'b0;
        end else begin
            serial_data_out_oe <= sda_low_nxt;
            serial_data_out <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Events, alert and ports
    ////////////////////////////////////////////////////////////////////////
    logic [NUM_PORTS-1:0] event_r;
    wire logic event_any;
    assign event_any = |event_r;

    // Events latch while pending; new events win over clearing.
    // Clearing happens at the end of a write transaction.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            event_r <= EVENT_RESET;
        end else if (stop_cond && state_r == ST_DATA) begin
            event_r <= port_event;
        end else begin
            event_r <= event_r | port_event;
        end
    end

    // RULE4: pull alert low for pending events
    // RULE10: update only while bus idle
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            alert_n_oe <= 1'b0;
            alert_n <= 1'b0;
        end else begin
            alert_n <= 1'b0;
            if (!busy_r) begin
                alert_n_oe <= event_any;
            end
        end
    end

    // RULE8: power gated by valid detection, one per port
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PORTS; gi++) begin : g_port
            always_ff @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    port_power_en[gi] <= 1'b0;
                end else begin
                    port_power_en[gi] <= pd_valid[gi] && (hw_mode || port_power_req[gi]);
                end
            end
        end
    endgenerate
endmodule // poe_pse_pin_host_front_end
`default_nettype wire

// >>> tb/i2c_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model (
    input wire logic ref_clk,
    input wire logic data_out_oe,
    input wire logic data_out,
    output wire logic scl,
    output wire logic sda
);
    // Host pull-low request on the data line
    logic pull_r = 1'b0;
    logic scl_r = 1'b1;
    assign sda = !pull_r && (data_out_oe ? data_out : 1'b1);
    assign scl = scl_r;
    ////////////////////////////////////////////////////////////
    // Waits n edges, then steps off the edge
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // Data changes only while the clock is low
    task automatic bit_io(input logic b, output logic r);
        pull_r = !b;
        tick(6);
        scl_r = 1'b1;
        tick(6);
        r = sda;
        scl_r = 1'b0;
    endtask
    task automatic start();
        pull_r = 1'b1;
        tick(6);
        scl_r = 1'b0;
    endtask
    task automatic stop();
        pull_r = 1'b1;
        tick(6);
        scl_r = 1'b1;
        tick(6);
        pull_r = 1'b0;
        tick(6);
    endtask
    // eight bits msb first, then release for the acknowledge
    task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic a);
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], q[i]);
        end
        bit_io(1'b1, a);
    endtask
endmodule // i2c_host_model
`default_nettype wire

// >>> tb/pse_front_chk.sv
`timescale 1ns/1ps
`default_nettype none
module pse_front_chk
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic mode_sel,
    input wire logic mid_sel,
    input wire logic addr_strap_0,
    input wire logic addr_strap_1,
    input wire logic addr_strap_2,
    input wire logic addr_strap_3,
    input wire logic scl,
    input wire logic serial_data_in,
    input wire logic serial_data_out_oe,
    input wire logic serial_data_out,
    input wire logic alert_n_oe,
    input wire logic alert_n,
    input wire logic [pse_front_pkg::NUM_PORTS-1:0] pd_valid,
    input wire logic [pse_front_pkg::NUM_PORTS-1:0] port_event,
    input wire logic [pse_front_pkg::NUM_PORTS-1:0] port_power_req,
    input wire logic [pse_front_pkg::NUM_PORTS-1:0] port_power_en,
    input wire logic hw_mode,
    input wire logic midspan_mode
);
    import pse_front_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////
    // Raw frame tracking, ahead of the design's own synchronisers
    logic scl_q, sda_q, busy_r;
    wire busy_nxt = (scl && scl_q && sda_q && !serial_data_in)
        || (busy_r && !(scl && scl_q && !sda_q && serial_data_in));
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            {scl_q, sda_q, busy_r} <= 3'h6;
        end else begin
            {scl_q, sda_q, busy_r} <= {scl, serial_data_in, busy_nxt};
        end
    end
    ////////////////////////////////////////////////////////////
    a_data_out_low: assert property (serial_data_out == 1'b0)
        else $error("data output not low");
    a_power_valid_only: assert property ((port_power_en & ~$past(pd_valid)) == 4'h0)
        else $error("power on invalid port");
    a_power_follow: assert property ($past(rst_n, 3) |-> port_power_en ==
        ($past(pd_valid) & ({NUM_PORTS{$past(hw_mode)}} | $past(port_power_req))))
        else $error("power enable wrong");
    a_mode_held: assert property ($past(rst_n, 6) |-> $stable(hw_mode) && $stable(midspan_mode))
        else $error("mode changed after capture");
    a_alert_quiet_busy: assert property (busy_r [*4] |-> $stable(alert_n_oe))
        else $error("alert changed in frame");
    a_oe_clock_low: assert property ($changed(serial_data_out_oe) |-> !scl && !scl_q)
        else $error("data moved with clock high");
    a_idle_released: assert property ((!busy_r) [*4] |-> !serial_data_out_oe)
        else $error("data driven while idle");
    a_alert_on_event: assert property ((!busy_r) [*4] ##1 (port_event != 4'h0) |-> ##[1:3] alert_n_oe)
        else $error("alert missing");
    c_ack: cover property (serial_data_out_oe);
    c_alert: cover property (alert_n_oe);
    c_frame: cover property (busy_r ##1 !busy_r);
endmodule // pse_front_chk
bind poe_pse_pin_host_front_end pse_front_chk u_chk (.*);
`default_nettype wire

// >>> tb/poe_pse_pin_host_front_end_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin mismatches++; $display("[ERR] %0t %h %h", $time, g, e); end end
module poe_pse_pin_host_front_end_tb_top;
    import pse_front_pkg::*;
    logic ref_clk = 0, rst_n = 0, mode_sel = 0, mid_sel = 0, a;
    logic [3:0] strap = 4'h0, pd_valid = 4'h0, port_event = 4'h0, req = 4'h0;
    logic [7:0] q;
    wire scl, sda, data_oe, data_out, alert_oe, alert_n, hw, mid;
    wire [3:0] pwr;
    int mismatches = 0, compares = 0;
    poe_pse_pin_host_front_end u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .mode_sel(mode_sel), .mid_sel(mid_sel),
        .addr_strap_0(strap[0]), .addr_strap_1(strap[1]), .addr_strap_2(strap[2]), .addr_strap_3(strap[3]),
        .scl(scl), .serial_data_in(sda), .serial_data_out_oe(data_oe), .serial_data_out(data_out),
        .alert_n_oe(alert_oe), .alert_n(alert_n), .pd_valid(pd_valid), .port_event(port_event),
        .port_power_req(req), .port_power_en(pwr),
        .hw_mode(hw), .midspan_mode(mid));
    i2c_host_model u_host (.ref_clk(ref_clk), .data_out_oe(data_oe), .data_out(data_out), .scl(scl), .sda(sda));
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    ////////////////////////////////////////////////////////////
    // Straps only count at power-up, so they change under reset
    task automatic do_reset(input logic [1:0] m, input logic [3:0] s);
        rst_n = 0;
        {mode_sel, mid_sel} = m;
        strap = s;
        u_host.tick(5);
        rst_n = 1;
        u_host.tick(8);
    endtask
    // Whole frame: address, one byte, stop even after a refusal
    task automatic txn(input logic [7:0] adr, output logic [7:0] rd, output logic ack);
        logic n;
        u_host.start();
        u_host.xfer(adr, rd, ack);
        u_host.xfer(adr[0] ? 8'hFF : 8'h00, rd, n);
        u_host.stop();
    endtask
    task automatic t_soft();
        `CHK({hw, mid}, 2'h1)
        pd_valid = 4'hB;
        req = 4'h9;
        u_host.tick(2);
        `CHK(pwr, 4'h9)
        req = 4'h6;
        u_host.tick(2);
        `CHK(pwr, 4'h2)
        txn(8'h41, q, a);
        `CHK({a, q}, 9'h002)
        txn(8'h42, q, a);
        `CHK(a, 1'b1)
    endtask
    task automatic t_alert();
        port_event = 4'h5;
        u_host.tick(1);
        port_event = 4'h0;
        u_host.tick(3);
        `CHK({alert_oe, alert_n}, 2'h2)
        txn(8'h40, q, a);
        u_host.tick(4);
        `CHK(alert_oe, 1'b0)
        u_host.start();
        u_host.xfer(8'h41, q, a);
        port_event = 4'hA;
        u_host.tick(1);
        port_event = 4'h0;
        u_host.tick(4);
        `CHK(alert_oe, 1'b0)
        u_host.xfer(8'hFF, q, a);
        u_host.stop();
        `CHK({alert_oe, alert_n}, 2'h2)
    endtask
    task automatic t_hard();
        `CHK({hw, mid}, 2'h2)
        `CHK(pwr, 4'hB)
        txn(8'h54, q, a);
        `CHK(a, 1'b0)
        txn(8'h40, q, a);
        `CHK(a, 1'b1)
        mode_sel = 0;
        u_host.tick(6);
        `CHK(hw, 1'b1)
    endtask
    // Both selects high and straps 0 and 2 move the address to 25h
    task automatic t_strap();
        pd_valid = 4'h5;
        do_reset(2'h3, 4'h5);
        `CHK({hw, mid}, 2'h3)
        `CHK(pwr, 4'h5)
        txn(8'h4B, q, a);
        `CHK({a, q}, 9'h005)
        txn(8'h41, q, a);
        `CHK(a, 1'b1)
    endtask
    task automatic final_report();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        do_reset(2'h1, 4'h0);
        t_soft();
        t_alert();
        do_reset(2'h2, 4'hA);
        t_hard();
        t_strap();
        final_report();
    end
    // Eight frames of some 250 cycles each; ample margin
    initial begin
        u_host.tick(20000);
        mismatches++;
        final_report();
    end
endmodule // poe_pse_pin_host_front_end_tb_top
`default_nettype wire
